//--- mnmh_pkg.sv
// Package of constants for the mesh node mode and host signalling block
`default_nettype none
package mnmh_pkg;
  // APB register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_HOST_TIMING = 8'h04;
  localparam logic [7:0] ADDR_NODE_ID = 8'h08;
  localparam logic [7:0] ADDR_MASTER_ID = 8'h0c;
  localparam logic [7:0] ADDR_RATE = 8'h10;
  localparam logic [7:0] ADDR_APP_NORMAL = 8'h14;
  localparam logic [7:0] ADDR_APP_ALT = 8'h18;
  localparam logic [7:0] ADDR_PASSWORD = 8'h1c;
  localparam logic [7:0] ADDR_NET_ID0 = 8'h20;
  localparam logic [7:0] ADDR_ONB_KEY0 = 8'h30;
  localparam logic [7:0] ADDR_CHAN_MAP0 = 8'h40;
  localparam logic [7:0] ADDR_STATUS = 8'h80;
  localparam logic [7:0] ADDR_CMD = 8'h84;
  // CTRL fields
  localparam int CTRL_TRACE_BIT = 0;
  localparam int CTRL_WAKE_AUTO_BIT = 1;
  localparam int CTRL_WAKE_MASTER_ONLY_BIT = 2;
  localparam int CTRL_HIB_NORMAL_BIT = 3;
  localparam int CTRL_HIB_ALT_SUPPRESS_BIT = 4;
  localparam int CTRL_APP_TYPE_LSB = 8;
  localparam int CTRL_LOGIN_LSB = 16;
  // CMD bits (write one to pulse)
  localparam int CMD_TX_EVENT_BIT = 0;
  localparam int CMD_RX_EVENT_BIT = 1;
  localparam int CMD_BEACON_EVENT_BIT = 2;
  localparam int CMD_HOST_DATA_BIT = 3;
  localparam int CMD_HOST_WAKE_BIT = 4;
  localparam int CMD_MASTER_GONE_BIT = 5;
  // Reset values
  localparam logic [7:0] CTS_INTERLEAVE_RST = 8'h01;
  localparam logic [7:0] CTS_TIMEOUT_RST = 8'h10;
  localparam logic [7:0] WAKE_TIME_RST = 8'h10;
  localparam logic [4:0] RATE_RST = 5'h01;
  localparam logic [4:0] RATE_MAX = 5'h1e;
  localparam logic [15:0] NODE_ID_RST = 16'hffff;
  // Identifier ranges
  localparam logic [15:0] ID_MIN = 16'h0001;
  localparam logic [15:0] ID_MAX = 16'hffef;
  localparam logic [15:0] ID_SINK_MAX = 16'h007f;
  localparam logic [15:0] ID_GROUP_MIN = 16'hfff0;
  localparam logic [15:0] ID_UNCONFIGURED = 16'hffff;
  // Logical channels
  localparam logic [4:0] CHAN_FIRST = 5'h01;
  localparam logic [4:0] CHAN_LAST = 5'h0f;
  localparam logic [4:0] CHAN_BEACON = 5'h10;
  localparam logic [4:0] CHAN_ONBOARD = 5'h11;
  localparam logic [4:0] CHAN_WAKE = 5'h12;
  localparam int NUM_CHAN = 18;
  // Wake burst kind carried with the network id
  localparam logic [1:0] BURST_NETWORK = 2'h1;
  // Host tick: 30.5 us at 50 MHz
  localparam int CLK_MHZ = 50;
  localparam int TICK_NS_X10 = 305000;
  localparam int TICK_CYCLES = TICK_NS_X10 / (10 * 1000 / CLK_MHZ);
  localparam logic [10:0] TICK_LAST = 11'(TICK_CYCLES - 1);
  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_CTS = 2'b01,
    HS_WAKE = 2'b10,
    HS_SEND = 2'b11
  } mnmh_host_state_t;
endpackage : mnmh_pkg
`default_nettype wire

//--- mnmh_node.sv
// Node mode control, configuration registers and host handshake pin timing
// Summary of operation
// R01: Automatic wake bursts are network-wide, carrying this node's network identifier.
// R02: Auto bursts run always when active, or only while the master is present.
// R03: The master node sends the current mode inside its normal traffic.
// R04: Mode settings are accepted only from the configured master node identifier.
// R05: Rate, application and hibernation settings have normal and alternate copies.
// R06: Alternate mode with suppression never hibernates, even if the master vanishes.
// R07: A login level may change its own and less privileged passwords only.
// R08: Trace output bit one enables trace on the system port, zero disables.
// R09: The 8-bit application type goes into every onboarding setup request.
// R10: Clear-to-send goes low once per N scheduled transmit events; default one.
// R11: Interleave zero asserts clear-to-send on every wake-up event.
// R12: Clear-to-send releases after 1..255 ticks of 30.5 us without host data.
// R13: After wake request low, wait 1..255 ticks before sending data.
// R14: Scheduled data uses logical channels 1 to 15 ascending, each mapped.
// R15: Channel 16 beacons, 17 onboarding, 18 wake beacons; none hop. The code never drives TX_CHANNEL to 18.
// R16: Node identifiers 0x0001..0xFFEF; 0x0001..0x007F are sink nodes.
// R17: Identifiers 0xFFF0..0xFFFE are group destinations, never own identifier.
// R18: Identifier 0xFFFF enters onboarding client mode and is also broadcast.
// R19: The 128-bit network identifier is also the radio AES key.
// R20: Onboarding traffic uses its own separate 128-bit AES key.
// R21: Normal-mode scheduled period is 1 to 30 whole seconds.
// R22: Every scheduled transmission moves to the next hopping channel.
// R23: A network burst wakes hibernating nodes whose network identifier matches.
// R24: After channel 15 the hopping pointer wraps to channel 1.
`default_nettype none
module mnmh_node (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic RX_MODE_VALID,
  input wire logic [15:0] RX_MODE_SRC_ID,
  input wire logic RX_MODE_ALT,
  input wire logic RX_BURST_VALID,
  input wire logic [127:0] RX_BURST_NET_ID,
  output logic TX_MODE_ALT,
  output logic CTS_N,
  output logic HOST_WAKE_REQUEST_N,
  output logic HOST_SEND_START,
  output logic WAKE_BURST_REQ,
  output logic [1:0] WAKE_BURST_KIND,
  output logic [127:0] WAKE_BURST_NET_ID,
  output logic [4:0] TX_CHANNEL,
  output logic [7:0] TX_FREQ,
  output logic [7:0] SETUP_APP_TYPE,
  output logic TRACE_EN,
  output logic HIBERNATE,
  output logic ONBOARD_CLIENT,
  output logic [4:0] SCHED_RATE_S,
  output logic [31:0] APP_SETTING
);
  logic [31:0] ctrl_q;
  logic [7:0] cts_interleave_q, cts_timeout_q, wake_time_q;
  logic [15:0] node_id_q, master_id_q;
  logic [4:0] rate_normal_q, rate_alt_q;
  logic [31:0] app_normal_q, app_alt_q;
  logic [2:0] pw_changed_q;
  logic [127:0] net_id_q, onb_key_q;
  logic [7:0] chan_map_q [0:mnmh_pkg::NUM_CHAN-1];
  logic mode_alt_q, master_present_q, hib_q;
  logic [4:0] chan_q;
  logic [7:0] ilv_cnt_q, tick_cnt_q;
  logic [10:0] pre_q;
  mnmh_pkg::mnmh_host_state_t hs_q;
  logic wr, rd;
  logic [31:0] cmd;
  logic [1:0] login;
  logic wake_any;
  logic cts_fire;

  assign wr = PSEL & PENABLE & PWRITE;
  assign rd = PSEL & ~PWRITE;
  assign cmd = (wr && PADDR == mnmh_pkg::ADDR_CMD) ? PWDATA : 32'h0;
  assign login = ctrl_q[mnmh_pkg::CTRL_LOGIN_LSB +: 2];
  assign wake_any = cmd[mnmh_pkg::CMD_TX_EVENT_BIT] | cmd[mnmh_pkg::CMD_RX_EVENT_BIT] |
    cmd[mnmh_pkg::CMD_BEACON_EVENT_BIT];
  // Interleave zero fires on any wake event, else once per N transmit events
  assign cts_fire = (cts_interleave_q == 8'h00) ? wake_any : // R11
    (cmd[mnmh_pkg::CMD_TX_EVENT_BIT] && ilv_cnt_q + 8'h01 >= cts_interleave_q); // R10

  // Configuration registers
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_q <= 32'h0;
      cts_interleave_q <= mnmh_pkg::CTS_INTERLEAVE_RST;
      cts_timeout_q <= mnmh_pkg::CTS_TIMEOUT_RST;
      wake_time_q <= mnmh_pkg::WAKE_TIME_RST;
      node_id_q <= mnmh_pkg::NODE_ID_RST;
      master_id_q <= 16'h0;
      rate_normal_q <= mnmh_pkg::RATE_RST;
      rate_alt_q <= mnmh_pkg::RATE_RST;
      app_normal_q <= 32'h0;
      app_alt_q <= 32'h0;
      pw_changed_q <= 3'h0;
    end else if (wr) begin
      case (PADDR)
        mnmh_pkg::ADDR_CTRL: begin
          ctrl_q <= PWDATA & 32'h0003_ff1f;
        end
        mnmh_pkg::ADDR_HOST_TIMING: begin
          cts_interleave_q <= PWDATA[7:0];
          if (PWDATA[15:8] != 8'h00) begin
            cts_timeout_q <= PWDATA[15:8]; // R12
          end
          if (PWDATA[23:16] != 8'h00) begin
            wake_time_q <= PWDATA[23:16]; // R13
          end
        end
        mnmh_pkg::ADDR_NODE_ID: begin
          // Group identifiers can never become our own
          if (PWDATA[15:0] < mnmh_pkg::ID_GROUP_MIN && PWDATA[15:0] >= mnmh_pkg::ID_MIN) begin // R16 R17
            node_id_q <= PWDATA[15:0];
          end else if (PWDATA[15:0] == mnmh_pkg::ID_UNCONFIGURED) begin // R18
            node_id_q <= PWDATA[15:0];
          end
        end
        mnmh_pkg::ADDR_MASTER_ID: begin
          master_id_q <= PWDATA[15:0]; // R04
        end
        mnmh_pkg::ADDR_RATE: begin
          if (PWDATA[4:0] != 5'h0 && PWDATA[4:0] <= mnmh_pkg::RATE_MAX) begin // R21
            rate_normal_q <= PWDATA[4:0];
          end
          if (PWDATA[12:8] != 5'h0 && PWDATA[12:8] <= mnmh_pkg::RATE_MAX) begin
            rate_alt_q <= PWDATA[12:8]; // R05
          end
        end
        mnmh_pkg::ADDR_APP_NORMAL: begin
          app_normal_q <= PWDATA; // R05
        end
        mnmh_pkg::ADDR_APP_ALT: begin
          app_alt_q <= PWDATA; // R05
        end
        mnmh_pkg::ADDR_PASSWORD: begin
          // Level 1 most privileged; target level in bits 1:0, login 0 means none
          if (login != 2'h0 && PWDATA[1:0] != 2'h0 && PWDATA[1:0] >= login) begin // R07
            pw_changed_q[PWDATA[1:0] - 2'h1] <= 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Wide keys and channel map
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      net_id_q <= 128'h0;
      onb_key_q <= 128'h0;
    end else if (wr) begin
      for (int i = 0; i < 4; i++) begin
        if (PADDR == mnmh_pkg::ADDR_NET_ID0 + 8'(4 * i)) begin
          net_id_q[32*i +: 32] <= PWDATA; // R19
        end
        if (PADDR == mnmh_pkg::ADDR_ONB_KEY0 + 8'(4 * i)) begin
          onb_key_q[32*i +: 32] <= PWDATA; // R20
        end
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < mnmh_pkg::NUM_CHAN; g++) begin : gen_map
      always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
          chan_map_q[g] <= 8'h0;
        end else if (wr && PADDR == mnmh_pkg::ADDR_CHAN_MAP0 + 8'(4 * g)) begin
          chan_map_q[g] <= PWDATA[7:0]; // R14
        end
      end
    end
  endgenerate

  // Network mode from the master only
  // A mode frame from the master in the same cycle outweighs a master-gone command
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      mode_alt_q <= 1'b0;
      master_present_q <= 1'b0;
    end else begin
      if (RX_MODE_VALID && RX_MODE_SRC_ID == master_id_q) begin // R04
        mode_alt_q <= RX_MODE_ALT;
        master_present_q <= 1'b1;
      end else if (cmd[mnmh_pkg::CMD_MASTER_GONE_BIT]) begin
        master_present_q <= 1'b0;
      end
    end
  end

  // Hibernation state
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      hib_q <= 1'b0;
    end else if (RX_BURST_VALID && RX_BURST_NET_ID == net_id_q) begin
      hib_q <= 1'b0; // R23
    end else if (mode_alt_q && ctrl_q[mnmh_pkg::CTRL_HIB_ALT_SUPPRESS_BIT]) begin
      hib_q <= 1'b0; // R06
    end else if (ctrl_q[mnmh_pkg::CTRL_HIB_NORMAL_BIT] && !master_present_q) begin
      hib_q <= 1'b1;
    end
  end

  // Hopping pointer on each scheduled transmit
  // Beacons and onboarding borrow fixed channels and leave the pointer alone
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      chan_q <= mnmh_pkg::CHAN_FIRST;
      TX_CHANNEL <= mnmh_pkg::CHAN_FIRST;
      TX_FREQ <= 8'h0;
    end else if (cmd[mnmh_pkg::CMD_TX_EVENT_BIT]) begin
      TX_CHANNEL <= chan_q; // R14
      TX_FREQ <= chan_map_q[chan_q - 5'h1];
      chan_q <= (chan_q == mnmh_pkg::CHAN_LAST) ? mnmh_pkg::CHAN_FIRST : chan_q + 5'h1; // R22 R24
    end else if (cmd[mnmh_pkg::CMD_BEACON_EVENT_BIT]) begin
      TX_CHANNEL <= mnmh_pkg::CHAN_BEACON; // R15
      TX_FREQ <= chan_map_q[mnmh_pkg::CHAN_BEACON - 5'h1];
    end else if (ONBOARD_CLIENT) begin
      TX_CHANNEL <= mnmh_pkg::CHAN_ONBOARD; // R15
      TX_FREQ <= chan_map_q[mnmh_pkg::CHAN_ONBOARD - 5'h1];
    end
  end

  // Interleave counter
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      ilv_cnt_q <= 8'h0;
    end else if (cmd[mnmh_pkg::CMD_TX_EVENT_BIT]) begin
      ilv_cnt_q <= (cts_interleave_q == 8'h00 || cts_fire) ? 8'h0 : ilv_cnt_q + 8'h01; // R10
    end
  end

  // Host pin sequencer, time in 30.5 us ticks
  // Prescaler is held at zero while idle, so every wait starts on a whole tick
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      hs_q <= mnmh_pkg::HS_IDLE;
      pre_q <= 11'h0;
      tick_cnt_q <= 8'h0;
      CTS_N <= 1'b1;
      HOST_WAKE_REQUEST_N <= 1'b1;
      HOST_SEND_START <= 1'b0;
    end else begin
      HOST_SEND_START <= 1'b0;
      pre_q <= (pre_q == mnmh_pkg::TICK_LAST || hs_q == mnmh_pkg::HS_IDLE) ? 11'h0 : pre_q + 11'h1;
      case (hs_q)
        mnmh_pkg::HS_IDLE: begin
          tick_cnt_q <= 8'h0;
          if (cmd[mnmh_pkg::CMD_HOST_WAKE_BIT]) begin
            hs_q <= mnmh_pkg::HS_WAKE;
            HOST_WAKE_REQUEST_N <= 1'b0; // R13
          end else if (cts_fire) begin
            hs_q <= mnmh_pkg::HS_CTS;
            CTS_N <= 1'b0; // R10
          end
        end
        mnmh_pkg::HS_CTS: begin
          if (cmd[mnmh_pkg::CMD_HOST_DATA_BIT]) begin
            hs_q <= mnmh_pkg::HS_IDLE;
            CTS_N <= 1'b1;
          end else if (pre_q == mnmh_pkg::TICK_LAST) begin
            if (tick_cnt_q + 8'h01 >= cts_timeout_q) begin // R12
              hs_q <= mnmh_pkg::HS_IDLE;
              CTS_N <= 1'b1;
            end
            tick_cnt_q <= tick_cnt_q + 8'h01;
          end
        end
        mnmh_pkg::HS_WAKE: begin
          if (pre_q == mnmh_pkg::TICK_LAST) begin
            if (tick_cnt_q + 8'h01 >= wake_time_q) begin // R13
              hs_q <= mnmh_pkg::HS_SEND;
            end
            tick_cnt_q <= tick_cnt_q + 8'h01;
          end
        end
        mnmh_pkg::HS_SEND: begin
          HOST_SEND_START <= 1'b1;
          HOST_WAKE_REQUEST_N <= 1'b1;
          hs_q <= mnmh_pkg::HS_IDLE;
        end
        default: begin
          hs_q <= mnmh_pkg::HS_IDLE;
        end
      endcase
    end
  end

  // Node outputs
  // A hibernating node issues no automatic bursts
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      TX_MODE_ALT <= 1'b0;
      WAKE_BURST_REQ <= 1'b0;
      WAKE_BURST_KIND <= mnmh_pkg::BURST_NETWORK;
      WAKE_BURST_NET_ID <= 128'h0;
      SETUP_APP_TYPE <= 8'h0;
      TRACE_EN <= 1'b0;
      HIBERNATE <= 1'b0;
      ONBOARD_CLIENT <= 1'b1;
      SCHED_RATE_S <= mnmh_pkg::RATE_RST;
      APP_SETTING <= 32'h0;
    end else begin
      TX_MODE_ALT <= mode_alt_q && node_id_q == master_id_q; // R03
      WAKE_BURST_REQ <= cmd[mnmh_pkg::CMD_TX_EVENT_BIT] && !hib_q && ctrl_q[mnmh_pkg::CTRL_WAKE_AUTO_BIT] &&
        (!ctrl_q[mnmh_pkg::CTRL_WAKE_MASTER_ONLY_BIT] || master_present_q); // R02
      WAKE_BURST_KIND <= mnmh_pkg::BURST_NETWORK; // R01
      WAKE_BURST_NET_ID <= net_id_q; // R01
      SETUP_APP_TYPE <= ctrl_q[mnmh_pkg::CTRL_APP_TYPE_LSB +: 8]; // R09
      TRACE_EN <= ctrl_q[mnmh_pkg::CTRL_TRACE_BIT]; // R08
      HIBERNATE <= hib_q;
      ONBOARD_CLIENT <= node_id_q == mnmh_pkg::ID_UNCONFIGURED; // R18
      SCHED_RATE_S <= mode_alt_q ? rate_alt_q : rate_normal_q; // R05
      APP_SETTING <= mode_alt_q ? app_alt_q : app_normal_q; // R05
    end
  end

  // APB read path, zero-wait
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      PRDATA <= 32'h0;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= PSEL & ~PENABLE;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0;
      if (rd && !PENABLE) begin
        case (PADDR)
          mnmh_pkg::ADDR_CTRL: begin
            PRDATA <= ctrl_q;
          end
          mnmh_pkg::ADDR_HOST_TIMING: begin
            PRDATA <= {8'h0, wake_time_q, cts_timeout_q, cts_interleave_q};
          end
          mnmh_pkg::ADDR_NODE_ID: begin
            PRDATA <= {16'h0, node_id_q};
          end
          mnmh_pkg::ADDR_MASTER_ID: begin
            PRDATA <= {16'h0, master_id_q};
          end
          mnmh_pkg::ADDR_RATE: begin
            PRDATA <= {19'h0, rate_alt_q, 3'h0, rate_normal_q};
          end
          mnmh_pkg::ADDR_APP_NORMAL: begin
            PRDATA <= app_normal_q;
          end
          mnmh_pkg::ADDR_APP_ALT: begin
            PRDATA <= app_alt_q;
          end
          mnmh_pkg::ADDR_PASSWORD: begin
            PRDATA <= {29'h0, pw_changed_q};
          end
          mnmh_pkg::ADDR_STATUS: begin
            PRDATA <= {16'h0, 3'h0, chan_q, 2'h0, hs_q,
              (node_id_q <= mnmh_pkg::ID_SINK_MAX && node_id_q != 16'h0), hib_q, master_present_q, mode_alt_q}; // R16
          end
          default: begin
            PSLVERR <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule : mnmh_node
`default_nettype wire

//--- mnmh_node_sva.sv
// Checker for the mesh node control block ports
`default_nettype none
module mnmh_node_sva (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic PREADY,
  input wire logic CTS_N,
  input wire logic HOST_WAKE_REQUEST_N,
  input wire logic HOST_SEND_START,
  input wire logic WAKE_BURST_REQ,
  input wire logic [1:0] WAKE_BURST_KIND,
  input wire logic [4:0] TX_CHANNEL,
  input wire logic [7:0] SETUP_APP_TYPE,
  input wire logic TRACE_EN,
  input wire logic [4:0] SCHED_RATE_S
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_N);
  logic [19:0] cts_cnt_q;
  logic [19:0] wake_cnt_q;
  logic wake_n_q;
  // Length of the current clear-to-send low run
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) cts_cnt_q <= 20'h0;
    else if (CTS_N) cts_cnt_q <= 20'h0;
    else cts_cnt_q <= cts_cnt_q + 20'h1;
  end
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) wake_n_q <= 1'b1;
    else wake_n_q <= HOST_WAKE_REQUEST_N;
  end
  // Cycles since the wake request last fell
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) wake_cnt_q <= 20'h0;
    else if (wake_n_q && !HOST_WAKE_REQUEST_N) wake_cnt_q <= 20'h1;
    else if (wake_cnt_q != 20'hfffff) wake_cnt_q <= wake_cnt_q + 20'h1;
  end
  sequence ctrl_wr_s;
    PSEL && PENABLE && PWRITE && PADDR == 8'h00;
  endsequence
  sequence tx_ev_s;
    PSEL && PENABLE && PWRITE && PADDR == 8'h84 && PWDATA[0];
  endsequence
  sequence bcn_ev_s;
    PSEL && PENABLE && PWRITE && PADDR == 8'h84 && PWDATA[2] && !PWDATA[0];
  endsequence
  burst_kind_a: assert property (WAKE_BURST_REQ |-> WAKE_BURST_KIND == 2'h1)
    else $error("auto burst is not network kind");
  chan_range_a: assert property (tx_ev_s |=> TX_CHANNEL >= 5'h01 && TX_CHANNEL <= 5'h0f)
    else $error("data channel outside hop list");
  bcn_chan_a: assert property (bcn_ev_s |=> TX_CHANNEL == 5'h10)
    else $error("beacon not on beacon channel");
  chan_step_a: assert property (TX_CHANNEL != $past(TX_CHANNEL) && $past(TX_CHANNEL) <= 5'h0f &&
    TX_CHANNEL <= 5'h0f |->
    TX_CHANNEL == (($past(TX_CHANNEL) == 5'h0f) ? 5'h01 : $past(TX_CHANNEL) + 5'h01))
    else $error("hop step wrong");
  rate_range_a: assert property (SCHED_RATE_S >= 5'h01 && SCHED_RATE_S <= 5'h1e)
    else $error("scheduled rate out of range");
  trace_set_a: assert property (ctrl_wr_s |-> ##2 TRACE_EN == $past(PWDATA[0], 2))
    else $error("trace enable not following write");
  app_type_a: assert property (ctrl_wr_s |-> ##2 SETUP_APP_TYPE == $past(PWDATA[15:8], 2))
    else $error("app type not following write");
  cts_hold_a: assert property (cts_cnt_q <= 20'h5ef15)
    else $error("clear to send held past timeout");
  wake_wait_a: assert property (HOST_SEND_START |-> wake_cnt_q >= 20'h005f0 && wake_cnt_q <= 20'h5ef15)
    else $error("send start outside wake interval");
  apb_ready_a: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("no ready in access cycle");
endmodule : mnmh_node_sva
bind mnmh_node mnmh_node_sva u_mnmh_node_sva (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .CTS_N(CTS_N),
  .HOST_WAKE_REQUEST_N(HOST_WAKE_REQUEST_N), .HOST_SEND_START(HOST_SEND_START),
  .WAKE_BURST_REQ(WAKE_BURST_REQ), .WAKE_BURST_KIND(WAKE_BURST_KIND), .TX_CHANNEL(TX_CHANNEL),
  .SETUP_APP_TYPE(SETUP_APP_TYPE), .TRACE_EN(TRACE_EN), .SCHED_RATE_S(SCHED_RATE_S));
`default_nettype wire

//--- mnmh_peer.sv
// Peer radio node model delivering mode fields
`default_nettype none
module mnmh_peer (
  input wire logic clk,
  output logic mode_valid,
  output logic [15:0] mode_src,
  output logic mode_alt,
  output logic burst_valid,
  output logic [127:0] burst_net
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    mode_valid = 1'b0;
    mode_src = 16'h0;
    mode_alt = 1'b0;
    burst_valid = 1'b0;
    burst_net = 128'h0;
  end
  // Network wake burst heard for one cycle, identifier scrambled once released
  task automatic send_burst(input logic [127:0] id);
    @(posedge clk);
    burst_valid <= 1'b1;
    burst_net <= id;
    @(posedge clk);
    burst_valid <= 1'b0;
    burst_net <= ~id;
  endtask : send_burst
  // Mode carried in one regular frame, fields scrambled once released
  task automatic send_mode(input logic [15:0] src, input logic alt);
    @(posedge clk);
    mode_valid <= 1'b1;
    mode_src <= src;
    mode_alt <= alt;
    @(posedge clk);
    mode_valid <= 1'b0;
    mode_src <= ~src;
    mode_alt <= ~alt;
  endtask : send_mode
endmodule : mnmh_peer
`default_nettype wire

//--- mnmh_node_tb_top.sv
// Testbench for the mesh node control block
`default_nettype none
module mnmh_node_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, mv, ma, tx_alt, cts_n, wake_n, send_go;
  logic breq, trace, hib, onb, bv;
  logic [7:0] paddr, freq, app_t;
  logic [31:0] pwdata, prdata, app_s, r;
  logic [15:0] msrc;
  logic [1:0] bkind;
  logic [127:0] bnet, bid;
  logic [4:0] chan, rate;
  int n_fail = 0;
  int tests_run = 0;
  mnmh_node u_mnmh_node (.CLK_SYS(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .RX_MODE_VALID(mv), .RX_MODE_SRC_ID(msrc), .RX_MODE_ALT(ma), .RX_BURST_VALID(bv),
    .RX_BURST_NET_ID(bid), .TX_MODE_ALT(tx_alt), .CTS_N(cts_n), .HOST_WAKE_REQUEST_N(wake_n),
    .HOST_SEND_START(send_go), .WAKE_BURST_REQ(breq), .WAKE_BURST_KIND(bkind), .WAKE_BURST_NET_ID(bnet),
    .TX_CHANNEL(chan), .TX_FREQ(freq), .SETUP_APP_TYPE(app_t), .TRACE_EN(trace), .HIBERNATE(hib),
    .ONBOARD_CLIENT(onb), .SCHED_RATE_S(rate), .APP_SETTING(app_s));
  mnmh_peer u_mnmh_peer (.clk(clk), .mode_valid(mv), .mode_src(msrc), .mode_alt(ma), .burst_valid(bv),
    .burst_net(bid));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic wcy(input int n);
    repeat (n) @(posedge clk);
  endtask : wcy
  task automatic cmd(input logic [31:0] b);
    apb(1'b1, 8'h84, b);
    wcy(2);
  endtask : cmd
  task automatic give_verdict;
    $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  task automatic t_cfg;
    chk("onb_rst", onb, 1'b1);
    chk("rate_rst", rate, 5'h01);
    apb(1'b1, 8'h00, 32'h0002a501);
    apb(1'b1, 8'h1c, 32'h1);
    apb(1'b1, 8'h1c, 32'h2);
    apb(1'b1, 8'h1c, 32'h3);
    apb(1'b0, 8'h1c, 32'h0);
    chk("pw_lvl", r, 32'h6);
    chk("trace_on", trace, 1'b1);
    chk("app_type", app_t, 8'ha5);
    apb(1'b1, 8'h00, 32'h00005a00);
    wcy(1);
    chk("trace_off", trace, 1'b0);
    chk("app_type2", app_t, 8'h5a);
    apb(1'b0, 8'h7c, 32'h0);
    chk("unmapped", r, 32'h0);
    $display("done t_cfg");
  endtask : t_cfg
  task automatic t_id;
    apb(1'b1, 8'h08, 32'hfff5);
    wcy(1);
    chk("grp_id", onb, 1'b1);
    apb(1'b1, 8'h08, 32'h0005);
    apb(1'b0, 8'h80, 32'h0);
    chk("sink", r[3], 1'b1);
    chk("onb_off", onb, 1'b0);
    apb(1'b1, 8'h08, 32'hffff);
    wcy(1);
    chk("onb_on", onb, 1'b1);
    apb(1'b1, 8'h08, 32'h0005);
    $display("done t_id");
  endtask : t_id
  task automatic t_hop;
    for (int c = 1; c <= 15; c++) apb(1'b1, 8'(8'h40 + 4 * (c - 1)), 32'(c * 7));
    for (int i = 0; i < 16; i++) begin
      cmd(32'h1);
      chk("chan", chan, 32'(i % 15 + 1));
      chk("freq", freq, 32'((i % 15 + 1) * 7));
      cmd(32'h8);
    end
    $display("done t_hop");
  endtask : t_hop
  task automatic t_cts;
    int lows;
    int k;
    lows = 0;
    apb(1'b1, 8'h04, 32'h00010102);
    repeat (2) begin
      cmd(32'h1);
      if (cts_n === 1'b0) lows++;
      cmd(32'h8);
    end
    chk("interleave", lows, 1);
    apb(1'b1, 8'h04, 32'h00010100);
    cmd(32'h2);
    chk("cts_rx", cts_n, 1'b0);
    k = 0;
    while (cts_n === 1'b0 && k < 3000) begin
      @(posedge clk);
      k++;
    end
    chk("cts_tmo", 32'(k >= 1515 && k <= 1530), 1);
    cmd(32'h4);
    chk("cts_bcn", cts_n, 1'b0);
    cmd(32'h8);
    chk("cts_rel", cts_n, 1'b1);
    $display("done t_cts");
  endtask : t_cts
  task automatic t_wake;
    int k;
    cmd(32'h10);
    chk("wake_low", wake_n, 1'b0);
    k = 0;
    while (send_go !== 1'b1 && k < 3000) begin
      @(posedge clk);
      k++;
    end
    chk("wake_time", 32'(k >= 1515 && k <= 1530), 1);
    wcy(2);
    chk("wake_rel", wake_n, 1'b1);
    $display("done t_wake");
  endtask : t_wake
  task automatic t_mode;
    apb(1'b1, 8'h0c, 32'h5);
    apb(1'b1, 8'h10, 32'h0703);
    apb(1'b1, 8'h14, 32'h11111111);
    apb(1'b1, 8'h18, 32'h22222222);
    u_mnmh_peer.send_mode(16'h0009, 1'b1);
    wcy(3);
    chk("rate_norm", rate, 5'h03);
    chk("app_norm", app_s, 32'h11111111);
    u_mnmh_peer.send_mode(16'h0005, 1'b1);
    wcy(3);
    chk("rate_alt", rate, 5'h07);
    chk("app_alt", app_s, 32'h22222222);
    chk("tx_alt", tx_alt, 1'b1);
    apb(1'b1, 8'h10, 32'h1f1f);
    wcy(1);
    chk("rate_bad", rate, 5'h07);
    apb(1'b1, 8'h00, 32'h18);
    cmd(32'h20);
    wcy(2);
    chk("no_hib", hib, 1'b0);
    $display("done t_mode");
  endtask : t_mode
  task automatic t_burst;
    for (int i = 0; i < 4; i++) apb(1'b1, 8'(8'h20 + 4 * i), 32'h5a5a0000 + 32'(i));
    apb(1'b1, 8'h00, 32'h2);
    apb(1'b1, 8'h84, 32'h1);
    chk("burst_req", breq, 1'b1);
    chk("burst_kind", bkind, 2'h1);
    chk("burst_net", 32'(bnet == 128'h5a5a00035a5a00025a5a00015a5a0000), 1);
    apb(1'b1, 8'h00, 32'h6);
    apb(1'b1, 8'h84, 32'h1);
    chk("burst_no_master", breq, 1'b0);
    apb(1'b1, 8'h00, 32'h8);
    apb(1'b1, 8'h00, 32'h0);
    wcy(1);
    chk("hib_on", hib, 1'b1);
    u_mnmh_peer.send_burst(128'h0);
    wcy(2);
    chk("hib_keep", hib, 1'b1);
    u_mnmh_peer.send_burst(128'h5a5a00035a5a00025a5a00015a5a0000);
    wcy(2);
    chk("hib_wake", hib, 1'b0);
    $display("done t_burst");
  endtask : t_burst
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    wcy(3);
    rst_n <= 1'b1;
    @(posedge clk);
    t_cfg();
    t_id();
    t_hop();
    t_cts();
    t_wake();
    t_mode();
    t_burst();
    give_verdict();
  end
  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    give_verdict();
  end
endmodule : mnmh_node_tb_top
`default_nettype wire
